// file: verilog/ilw_log_writer.sv
// interrupt log writer: records events into the circular ram log
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - log is a circular 64-word ram region, words 0x0180 to 0x01BF
// - each record writes exactly two words; buffer keeps the last 32
// - after every 32nd record the pointer returns to 0x0180
// - record is an identification word then a context address word
// - identification at even address, address word at the next odd
// - id bits 2:0 give source type; controller records set bit 0
// - id bits 15:3 copy the source's pending event bits
// - several event bits may share one identification word
// - hardware records write address word zero, except parity failure
// - parity failure records write the failing ram address
// - controller records write the block status word address
// - terminal records write the descriptor entry start address
// - with busy option set, terminal id bit 9 shows terminal busy
// - busy state alone never makes a record or an interrupt
// - events of one terminal in one message share one record
// - controller and terminal events each get their own record
// - enabled events are ored into one active-low interrupt request
// - pointer bits 15:9 count records, stop at 127, clear on read
// - reset gives pointer 0x0180, count zero; pointer even, 8:6 = 110
module ilw_log_writer
  import ilw_pkg::*;
#(
  parameter int RAM_AW = 13
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // hardware event source
  input wire logic hw_evt,
  input wire logic [15:3] hw_bits,
  input wire logic [RAM_AW-1:0] hw_parity_addr,
  input wire logic hw_out_en,
  // bus controller event source
  input wire logic bc_evt,
  input wire logic [15:3] bc_bits,
  input wire logic [15:0] bc_status_addr,
  input wire logic bc_out_en,
  // remote terminal event source
  input wire logic rt_evt,
  input wire logic [15:3] rt_bits,
  input wire logic [15:0] rt_desc_addr,
  input wire logic rt_busy,
  input wire logic rt_out_en,
  // host register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // ram write port
  output logic ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic [15:0] ram_wdata,
  // shared interrupt request
  output logic irq_n
);
  ilw_state_e state;
  logic [1:0] wr_sel;
  logic [15:0] wr_id;
  logic [15:0] wr_ad;
  logic [ILW_IDX_W-1:0] idx;
  logic [ILW_CNT_W-1:0] cnt;
  logic busy_logging_option;
  logic irq_pend;

  // source words
  logic [15:0] new_id [ILW_NSRC];
  logic [15:0] new_ad [ILW_NSRC];
  logic [15:0] slot_id [ILW_NSRC];
  logic [15:0] slot_ad [ILW_NSRC];
  logic [ILW_NSRC-1:0] cap;
  logic [ILW_NSRC-1:0] full;
  logic [ILW_NSRC-1:0] take;
  logic [ILW_NSRC-1:0] oe;

  wire [15:0] hw_word = {hw_bits, ILW_TYPE_HW};
  wire hw_pf = hw_word[ILW_HW_PF_BIT];
  wire [15:0] rt_raw = {rt_bits, ILW_TYPE_RT};
  // bit 9 is borrowed for the busy flag, so it is no event then
  wire [12:0] rt_evt_bits = busy_logging_option ?
    (rt_bits & ~13'h0040) : rt_bits;

  assign cap[ILW_SRC_HW] = hw_evt && (|hw_bits);
  assign cap[ILW_SRC_BC] = bc_evt && (|bc_bits);
  assign cap[ILW_SRC_RT] = rt_evt && (|rt_evt_bits);
  assign oe = {rt_out_en, bc_out_en, hw_out_en};

  assign new_id[ILW_SRC_HW] = hw_word;
  assign new_id[ILW_SRC_BC] = {bc_bits, ILW_TYPE_BC};
  assign new_id[ILW_SRC_RT] = busy_logging_option ?
    {rt_raw[15:10], rt_busy, rt_raw[8:0]} : rt_raw;
  assign new_ad[ILW_SRC_HW] = hw_pf ?
    16'(hw_parity_addr) : ILW_WORD_ZERO;
  assign new_ad[ILW_SRC_BC] = bc_status_addr;
  assign new_ad[ILW_SRC_RT] = rt_desc_addr;

  // grant picks the lowest pending source
  wire any_full = |full;
  wire [1:0] grant = full[ILW_SRC_HW] ? ILW_SRC_HW :
    full[ILW_SRC_BC] ? ILW_SRC_BC : ILW_SRC_RT;
  wire start = (state == ILW_IDLE) && any_full;

  // each source keeps its own slot, so simultaneous sources
  // become separate records while bits of one source merge
  genvar g;
  generate
    for (g = 0; g < ILW_NSRC; g++) begin : g_src
      assign take[g] = start && (grant == 2'(g));
      ilw_event_slot #(.W(16)) u_slot (
        .mclk(mclk),
        .rst(rst),
        .capture(cap[g]),
        .new_id(new_id[g]),
        .new_addr(new_ad[g]),
        .take(take[g]),
        .full(full[g]),
        .id(slot_id[g]),
        .addr(slot_ad[g])
      );
    end
  endgenerate

  // record sequencer
  ilw_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      ILW_IDLE: begin
        if (any_full) begin
          next_state = ILW_WR_ID;
        end
      end
      ILW_WR_ID: begin
        next_state = ILW_WR_AD;
      end
      ILW_WR_AD: begin
        next_state = ILW_IDLE;
      end
      default: begin
        next_state = ILW_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ILW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // the record is copied out so the slot can refill during the write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_sel <= ILW_SRC_HW;
      wr_id <= ILW_WORD_ZERO;
      wr_ad <= ILW_WORD_ZERO;
    end else if (start) begin
      wr_sel <= grant;
      wr_id <= slot_id[grant];
      wr_ad <= slot_ad[grant];
    end
  end

  // pointer and ram outputs
  wire [8:0] ptr = ILW_LOG_BASE | {3'h0, idx, 1'b0};
  wire in_id = (state == ILW_WR_ID);
  wire in_ad = (state == ILW_WR_AD);
  wire [8:0] next_ram_addr = in_ad ? (ptr | 9'h001) : ptr;
  wire [15:0] next_ram_wdata = in_ad ? wr_ad : wr_id;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ram_we <= 1'b0;
      ram_addr <= '0;
      ram_wdata <= ILW_WORD_ZERO;
    end else begin
      ram_we <= in_id || in_ad;
      ram_addr <= RAM_AW'(next_ram_addr);
      ram_wdata <= next_ram_wdata;
    end
  end

  // the index wraps by its own width after the 32nd record
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idx <= ILW_IDX_RST;
    end else if (in_ad) begin
      idx <= idx + 5'h01;
    end
  end

  // host register port
  wire rd_ptr = reg_rd && (reg_addr == ILW_REG_PTR);
  wire wr_xcfg = reg_wr && (reg_addr == ILW_REG_XCFG);
  wire [15:0] ptr_word = {cnt, ptr};
  wire [15:0] xcfg_word = 16'(busy_logging_option) << ILW_XCFG_BUSY_BIT;
  wire [15:0] next_rdata = !reg_rd ? ILW_WORD_ZERO :
    (reg_addr == ILW_REG_PTR) ? ptr_word :
    (reg_addr == ILW_REG_XCFG) ? xcfg_word : ILW_WORD_ZERO;

  // a record finishing in the read cycle counts after the clear
  wire cnt_sat = (cnt == ILW_CNT_MAX);
  wire [6:0] next_cnt = rd_ptr ? 7'(in_ad) :
    (in_ad && !cnt_sat) ? cnt + 7'h01 : cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= ILW_CNT_RST;
      reg_rdata <= ILW_WORD_ZERO;
      busy_logging_option <= 1'b0;
    end else begin
      cnt <= next_cnt;
      reg_rdata <= next_rdata;
      if (wr_xcfg) begin
        busy_logging_option <= reg_wdata[ILW_XCFG_BUSY_BIT];
      end
    end
  end

  // interrupt request holds until the host reads the pointer register
  wire next_irq = (|(cap & oe)) || (irq_pend && !rd_ptr);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_pend <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      irq_pend <= next_irq;
      irq_n <= !next_irq;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_id_word;
    ram_we && !ram_addr[0];
  endsequence

  sequence s_ad_word;
    ram_we && ram_addr[0];
  endsequence

  chk_ptr_shape: assert property (
    ptr[8:6] == 3'h6 && !ptr[0] && ptr >= ILW_LOG_BASE
  ) else $error("pointer left the log region");

  chk_record_pair: assert property (
    s_id_word |=> s_ad_word ##1 !ram_we
  ) else $error("record is not exactly two words");

  chk_pair_addr: assert property (
    s_id_word |=> ram_addr == $past(ram_addr) + RAM_AW'(1)
  ) else $error("address word not at next odd address");

  chk_ptr_wrap: assert property (
    ram_we && ram_addr == RAM_AW'(ILW_LOG_LAST) |-> ptr == ILW_LOG_BASE
  ) else $error("pointer did not wrap after last record");

  chk_ptr_step: assert property (
    (s_ad_word and (ram_addr != RAM_AW'(ILW_LOG_LAST)))
      |-> RAM_AW'(ptr) == ram_addr + RAM_AW'(1)
  ) else $error("pointer did not advance by two");

  chk_count_hold: assert property (
    cnt == ILW_CNT_MAX && !rd_ptr |=> cnt == ILW_CNT_MAX
  ) else $error("count passed its ceiling");

  chk_count_clear: assert property (
    rd_ptr && !in_ad |=> cnt == ILW_CNT_RST
  ) else $error("count not cleared by read");

  chk_bc_type: assert property (
    in_id && wr_sel == ILW_SRC_BC |=> (s_id_word and ram_wdata[0])
  ) else $error("controller record lacks type bit");

  chk_hw_zero: assert property (
    in_ad && wr_sel == ILW_SRC_HW && !wr_id[ILW_HW_PF_BIT]
      |=> (s_ad_word and (ram_wdata == ILW_WORD_ZERO))
  ) else $error("hardware address word not zero");

  chk_busy_only: assert property (
    rt_evt && busy_logging_option && rt_evt_bits == 13'h0000
      && !full[ILW_SRC_RT] |=> !full[ILW_SRC_RT]
  ) else $error("busy alone produced a record");

  chk_irq_out: assert property (
    |(cap & oe) |=> !irq_n ##1 (!irq_n || $past(rd_ptr))
  ) else $error("enabled event did not raise interrupt");

  chk_count_step: assert property (
    in_ad && !rd_ptr && !cnt_sat |=> cnt == $past(cnt) + 7'h01
  ) else $error("count did not step on a record");

  chk_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == ILW_WORD_ZERO
  ) else $error("read data stood beyond its cycle");
endmodule

// file: verilog/ilw_pkg.sv
// constants and types for the interrupt log buffer writer
package ilw_pkg;
  // log region in ram, word addresses
  localparam logic [8:0] ILW_LOG_BASE = 9'h180;
  localparam logic [8:0] ILW_LOG_LAST = 9'h1BF;
  localparam int ILW_IDX_W = 5;
  // event count held in the upper pointer register bits
  localparam int ILW_CNT_W = 7;
  localparam logic [6:0] ILW_CNT_MAX = 7'h7F;
  localparam logic [6:0] ILW_CNT_RST = 7'h00;
  localparam logic [4:0] ILW_IDX_RST = 5'h00;
  // register offsets on the host port
  localparam logic [7:0] ILW_REG_PTR = 8'h0A;
  localparam logic [7:0] ILW_REG_XCFG = 8'h4D;
  localparam int ILW_XCFG_BUSY_BIT = 2;
  // identification word fields
  localparam int ILW_ID_BUSY_BIT = 9;
  localparam int ILW_HW_PF_BIT = 11;
  localparam logic [2:0] ILW_TYPE_HW = 3'h0;
  localparam logic [2:0] ILW_TYPE_BC = 3'h1;
  localparam logic [2:0] ILW_TYPE_RT = 3'h4;
  localparam logic [15:0] ILW_WORD_ZERO = 16'h0000;
  // event sources, lower index is served first
  localparam int ILW_NSRC = 3;
  localparam logic [1:0] ILW_SRC_HW = 2'h0;
  localparam logic [1:0] ILW_SRC_BC = 2'h1;
  localparam logic [1:0] ILW_SRC_RT = 2'h2;
  typedef enum logic [1:0] {ILW_IDLE, ILW_WR_ID, ILW_WR_AD} ilw_state_e;
endpackage

// file: verilog/ilw_event_slot.sv
// one pending record per event source, merging events that arrive early
`timescale 1ns/1ps
module ilw_event_slot
  import ilw_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // new event
  input wire logic capture,
  input wire logic [W-1:0] new_id,
  input wire logic [W-1:0] new_addr,
  // writer takes the record
  input wire logic take,
  output logic full,
  output logic [W-1:0] id,
  output logic [W-1:0] addr
);
  // merge only when the held record stays; a take in the same cycle
  // loses nothing because the fresh event is loaded whole
  wire merge = full && !take;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      full <= 1'b0;
      id <= '0;
      addr <= '0;
    end else if (capture) begin
      full <= 1'b1;
      id <= merge ? (id | new_id) : new_id;
      addr <= merge ? addr : new_addr;
    end else if (take) begin
      full <= 1'b0;
    end
  end
endmodule

// file: bench/ilw_ram_model.sv
// ram model for the log region, catching writes that stray outside it
`timescale 1ns/1ps
module ilw_ram_model
  import ilw_pkg::*;
#(
  parameter int RAM_AW = 13
) (
  // clock
  input wire logic mclk,
  // write port from the writer
  input wire logic ram_we,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  // bookkeeping seen by the bench
  output logic stray,
  output int unsigned writes
);
  logic [15:0] mem [0:511];
  initial begin
    stray = 1'b0;
    writes = 0;
  end
  always @(posedge mclk) begin
    if (ram_we === 1'b1) begin
      mem[ram_addr[8:0]] <= ram_wdata;
      writes <= writes + 1;
      // upper address bits are compared too, so aliasing is caught
      if (ram_addr < RAM_AW'(ILW_LOG_BASE) ||
          ram_addr > RAM_AW'(ILW_LOG_LAST)) begin
        stray <= 1'b1;
      end
    end
  end
endmodule

// file: bench/test_ilw_log_writer.sv
// self-checking bench for the interrupt log writer
`timescale 1ns/1ps
module test_ilw_log_writer
  import ilw_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hw_evt = 1'b0, bc_evt = 1'b0, rt_evt = 1'b0, rt_busy = 1'b0;
  logic [15:3] hw_bits = '0, bc_bits = '0, rt_bits = '0;
  logic [12:0] hw_parity_addr = 13'h0ABC;
  logic [15:0] bc_status_addr = 16'h1234, rt_desc_addr = 16'h0F40;
  logic hw_out_en = 1'b0, bc_out_en = 1'b1, rt_out_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, ram_wdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ram_we, irq_n, stray;
  logic [12:0] ram_addr;
  logic [8:0] eptr = 9'h180;
  logic [6:0] ecnt = 7'h00;
  int unsigned writes;
  int mismatches = 0, checked = 0, cycles = 0, ew = 0;

  always #50 mclk = ~mclk;

  ilw_log_writer #(.RAM_AW(13)) DUT (.mclk(mclk), .rst(rst),
    .hw_evt(hw_evt), .hw_bits(hw_bits), .hw_parity_addr(hw_parity_addr),
    .hw_out_en(hw_out_en), .bc_evt(bc_evt), .bc_bits(bc_bits),
    .bc_status_addr(bc_status_addr), .bc_out_en(bc_out_en),
    .rt_evt(rt_evt), .rt_bits(rt_bits), .rt_desc_addr(rt_desc_addr),
    .rt_busy(rt_busy), .rt_out_en(rt_out_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .irq_n(irq_n));

  ilw_ram_model #(.RAM_AW(13)) ram (.mclk(mclk), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .stray(stray),
    .writes(writes));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize;
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask

  // one-cycle event pulse, then time for up to three records
  task ev(input logic h, b, r, input logic [15:3] hb, bb, rb);
    @(posedge mclk);
    hw_evt <= h;
    bc_evt <= b;
    rt_evt <= r;
    hw_bits <= hb;
    bc_bits <= bb;
    rt_bits <= rb;
    @(posedge mclk);
    hw_evt <= 1'b0;
    bc_evt <= 1'b0;
    rt_evt <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask

  task rec(input logic [15:0] id, input logic [15:0] ad);
    check(ram.mem[eptr], id);
    check(ram.mem[eptr + 9'h1], ad);
    eptr = (eptr == 9'h1BE) ? ILW_LOG_BASE : eptr + 9'h2;
    if (ecnt != ILW_CNT_MAX) ecnt = ecnt + 7'h1;
    ew += 2;
  endtask

  task ptr_chk;
    rd(ILW_REG_PTR, d);
    check(d, {ecnt, eptr});
    ecnt = ILW_CNT_RST;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize;
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    ptr_chk;
    @(negedge mclk);
    check(reg_rdata, 16'h0000);
    rd(ILW_REG_XCFG, d);
    check(d, 16'h0000);
    rd(8'h33, d);
    check(d, 16'h0000);
    ev(1'b0, 1'b1, 1'b0, '0, 13'h0A5A, '0);
    rec({13'h0A5A, ILW_TYPE_BC}, 16'h1234);
    check({15'h0, irq_n}, 16'h0000);
    ptr_chk;
    check({15'h0, irq_n}, 16'h0001);
    ev(1'b1, 1'b0, 1'b0, 13'h0100, '0, '0);
    rec(16'h0800, 16'h0ABC);
    ev(1'b1, 1'b0, 1'b0, 13'h0010, '0, '0);
    rec(16'h0080, 16'h0000);
    check({15'h0, irq_n}, 16'h0001);
    // controller and terminal in the same cycle, a second terminal event merges
    @(posedge mclk);
    bc_evt <= 1'b1;
    rt_evt <= 1'b1;
    bc_bits <= 13'h0002;
    rt_bits <= 13'h0004;
    @(posedge mclk);
    bc_evt <= 1'b0;
    rt_bits <= 13'h0008;
    ev(1'b0, 1'b0, 1'b0, '0, '0, '0);
    rec(16'h0011, 16'h1234);
    rec(16'h0064, 16'h0F40);
    ptr_chk;
    wr(ILW_REG_XCFG, 16'hFFFF);
    rd(ILW_REG_XCFG, d);
    check(d, 16'h0004);
    @(posedge mclk);
    rt_busy <= 1'b1;
    ev(1'b0, 1'b0, 1'b1, '0, '0, 13'h0040);
    check({15'h0, irq_n}, 16'h0001);
    ptr_chk;
    ev(1'b0, 1'b0, 1'b1, '0, '0, 13'h0001);
    rec(16'h020C, 16'h0F40);
    check({15'h0, irq_n}, 16'h0000);
    // over four laps of the log without a read, so the count saturates
    for (int i = 0; i < 130; i++) begin
      ev(1'b1, 1'b0, 1'b0, 13'(i + 1), '0, '0);
      rec({13'(i + 1), ILW_TYPE_HW}, 16'h0000);
    end
    wr(ILW_REG_PTR, 16'h0000);
    ptr_chk;
    ptr_chk;
    check({15'h0, irq_n}, 16'h0001);
    check(16'(writes), 16'(ew));
    check({15'h0, stray}, 16'h0000);
    summarize;
  end
endmodule
